// file: design/adc_control_registers.sv
`timescale 1ns/1ps
// How it works
// - The converter is enabled and clocked only while control bit 7 is 1, and it is 0 after reset.
// - Control bit 6 reads 1 when the converter is ready and its result may be taken.
// - Control bits 5 to 2 pick the input: 1-7 port B lines 0-6, 8 PA3, 9 PA4, 10 PA0, 15 the bandgap.
// - The channel resets to 1, and code 0 and every unassigned code route no input.
// - The converter clock is the system clock divided by two to the power of mode bits 3 to 1, reset 0.
// - Reference bit 7 picks the external pin over the supply, resets to 0 and reads back as zero.
// - The result register returns the last conversion result and ignores writes.
module adc_control_registers
(
  input wire logic i_mclk,
  input wire logic i_srst,
  input wire adc_pkg::io_req_t i_io,
  input wire logic i_conv_done,
  input wire logic [7:0] i_conv_result,
  output logic [7:0] o_io_rdata,
  output logic o_conv_enable,
  output logic o_conv_start,
  output logic o_conv_clk_tick,
  output logic o_ref_external,
  output adc_pkg::chan_route_t o_chan_route
);

  // ****************************************************************
  // Register state.
  // ****************************************************************
  logic en_q, en_d;
  logic busy_q, busy_d;
  logic [3:0] chan_q, chan_d;
  logic [2:0] div_q, div_d;
  logic ref_q, ref_d;
  logic [7:0] result_q, result_d;
  logic [7:0] rdata_q, rdata_d;
  logic start_q, start_d;
  logic [6:0] cnt_q, cnt_d;
  logic tick_q, tick_d;
  adc_pkg::chan_route_t route_q, route_d;
  logic wr_ctrl, wr_mode, wr_ref;
  logic start_req;
  logic [6:0] div_mask;

  // Decodes a channel code into mux select lines; undefined codes select nothing.
  function automatic adc_pkg::chan_route_t decode_chan(input logic [3:0] code);
    adc_pkg::chan_route_t r;
    r = '0;
    if (code >= 4'h1 && code <= 4'h7)
    begin
      r.port_b_line = 7'(7'h01 << (code - 4'h1));
    end
    r.port_a_line3 = (code == adc_pkg::CHAN_PA3);
    r.port_a_line4 = (code == adc_pkg::CHAN_PA4);
    r.port_a_line0 = (code == adc_pkg::CHAN_PA0);
    r.bandgap = (code == adc_pkg::CHAN_BANDGAP);
    return r;
  endfunction

  // Address decode of the write strobe.
  assign wr_ctrl = i_io.wr && (i_io.addr == adc_pkg::CTRL_ADDR);
  assign wr_mode = i_io.wr && (i_io.addr == adc_pkg::MODE_ADDR);
  assign wr_ref = i_io.wr && (i_io.addr == adc_pkg::REF_ADDR);
  assign start_req = wr_ctrl && i_io.wdata[adc_pkg::CTRL_PROC_BIT] && i_io.wdata[adc_pkg::CTRL_EN_BIT];
  assign div_mask = adc_pkg::DIV_ALL >> (adc_pkg::DIV_MAX_CODE - div_q);

  // ****************************************************************
  // Next-state logic for registers, conversion and divider.
  // ****************************************************************

  // A start in the same cycle as a completion wins, so a new request is never lost.
  always_comb
  begin
    en_d = en_q;
    chan_d = chan_q;
    div_d = div_q;
    ref_d = ref_q;
    busy_d = busy_q;
    result_d = result_q;
    if (wr_ctrl)
    begin
      en_d = i_io.wdata[adc_pkg::CTRL_EN_BIT];
      chan_d = i_io.wdata[adc_pkg::CTRL_CHAN_HI:adc_pkg::CTRL_CHAN_LO];
    end
    if (wr_mode)
    begin
      div_d = i_io.wdata[adc_pkg::MODE_DIV_HI:adc_pkg::MODE_DIV_LO];
    end
    if (wr_ref)
    begin
      ref_d = i_io.wdata[adc_pkg::REF_EXT_BIT];
    end
    if (busy_q && i_conv_done)
    begin
      busy_d = 1'b0;
      result_d = i_conv_result;
    end
    if (!en_d)
    begin
      busy_d = 1'b0;
    end
    if (start_req)
    begin
      busy_d = 1'b1;
    end
    start_d = start_req;
    route_d = decode_chan(chan_d);
    cnt_d = en_q ? cnt_q + 7'h01 : 7'h00;
    tick_d = en_q && ((cnt_q & div_mask) == div_mask);
  end

  // Read mux; write-only and reserved bits read as zero.
  always_comb
  begin
    rdata_d = rdata_q;
    if (i_io.rd)
    begin
      unique case (i_io.addr)
        adc_pkg::CTRL_ADDR: rdata_d = {en_q, !busy_q, chan_q, 2'b00};
        adc_pkg::MODE_ADDR: rdata_d = {4'h0, div_q, 1'b0};
        adc_pkg::RESULT_ADDR: rdata_d = result_q;
        default: rdata_d = 8'h00;
      endcase
    end
  end

  // Registers all state; the synchronous reset loads the documented values.
  always_ff @(posedge i_mclk)
  begin
    if (i_srst)
    begin
      en_q <= adc_pkg::RESET_EN;
      busy_q <= 1'b0;
      chan_q <= adc_pkg::RESET_CHAN;
      div_q <= adc_pkg::RESET_DIV;
      ref_q <= adc_pkg::RESET_REF_EXT;
      result_q <= adc_pkg::RESET_RESULT;
      rdata_q <= 8'h00;
      start_q <= 1'b0;
      cnt_q <= 7'h00;
      tick_q <= 1'b0;
      route_q <= '0;
    end
    else
    begin
      en_q <= en_d;
      busy_q <= busy_d;
      chan_q <= chan_d;
      div_q <= div_d;
      ref_q <= ref_d;
      result_q <= result_d;
      rdata_q <= rdata_d;
      start_q <= start_d;
      cnt_q <= cnt_d;
      tick_q <= tick_d;
      route_q <= route_d;
    end
  end

  // Outputs come straight from flip-flops.
  assign o_io_rdata = rdata_q;
  assign o_conv_enable = en_q;
  assign o_conv_start = start_q;
  assign o_conv_clk_tick = tick_q;
  assign o_ref_external = ref_q;
  assign o_chan_route = route_q;

  // ****************************************************************
  // Checks.
  // ****************************************************************

  // Helper that measures the spacing of divider ticks at a steady ratio.
  logic [7:0] gap_q;
  logic steady_q;
  logic wr_mode_q;
  always_ff @(posedge i_mclk)
  begin
    if (i_srst)
    begin
      gap_q <= 8'h00;
      steady_q <= 1'b0;
      wr_mode_q <= 1'b0;
    end
    else
    begin
      gap_q <= tick_q ? 8'h00 : gap_q + 8'h01;
      // The tick just after a ratio change still follows the old ratio, so spacing restarts from a later tick.
      steady_q <= (tick_q || steady_q) && en_q && !wr_mode && !wr_mode_q;
      wr_mode_q <= wr_mode;
    end
  end

  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_srst);

  property p_off_no_tick;
    !en_q |=> !tick_q && busy_q == $past(start_req);
  endproperty
  a_off_no_tick: assert property (p_off_no_tick) else $error("Converter active while disabled.");

  property p_ready_read;
    i_io.rd && i_io.addr == adc_pkg::CTRL_ADDR |=> o_io_rdata[adc_pkg::CTRL_PROC_BIT] == !$past(busy_q);
  endproperty
  a_ready_read: assert property (p_ready_read) else $error("Ready bit read wrong.");

  property p_route_pa0;
    wr_ctrl && i_io.wdata[adc_pkg::CTRL_CHAN_HI:adc_pkg::CTRL_CHAN_LO] == adc_pkg::CHAN_PA0
      |=> o_chan_route.port_a_line0 && $onehot(o_chan_route);
  endproperty
  a_route_pa0: assert property (p_route_pa0) else $error("Port A line 0 not routed.");

  property p_route_reserved;
    chan_q == 4'h0 || (chan_q > adc_pkg::CHAN_PA0 && chan_q < adc_pkg::CHAN_BANDGAP) |-> o_chan_route == '0;
  endproperty
  a_route_reserved: assert property (p_route_reserved) else $error("Reserved channel routed an input.");

  property p_tick_spacing;
    tick_q && steady_q |-> gap_q == 8'((8'h01 << div_q) - 8'h01);
  endproperty
  a_tick_spacing: assert property (p_tick_spacing) else $error("Divider tick spacing wrong.");

  property p_ref_wo;
    (wr_ref |=> o_ref_external == $past(i_io.wdata[adc_pkg::REF_EXT_BIT]))
      and (i_io.rd && i_io.addr == adc_pkg::REF_ADDR |=> o_io_rdata == 8'h00);
  endproperty
  a_ref_wo: assert property (p_ref_wo) else $error("Reference register misbehaves.");

  property p_result_capture;
    (busy_q && i_conv_done |=> result_q == $past(i_conv_result))
      and (i_io.rd && i_io.addr == adc_pkg::RESULT_ADDR |=> o_io_rdata == $past(result_q))
      and (i_io.wr && i_io.addr == adc_pkg::RESULT_ADDR && !(busy_q && i_conv_done) |=> $stable(result_q));
  endproperty
  a_result_capture: assert property (p_result_capture) else $error("Result not captured.");

  property p_start;
    start_req |=> o_conv_start && busy_q ##1 o_conv_start == $past(start_req);
  endproperty
  a_start: assert property (p_start) else $error("Start not issued or busy not set.");

  c_convert: cover property (start_req ##[1:50] (busy_q && i_conv_done));
  c_slow_div: cover property (tick_q && steady_q && div_q == 3'h3);
  c_bandgap: cover property (o_chan_route.bandgap && o_conv_enable);

endmodule // adc_control_registers

// file: common/adc_pkg.sv
package adc_pkg;

  // ****************************************************************
  // Register map in the I/O space.
  // ****************************************************************
  localparam logic [5:0] CTRL_ADDR = 6'h3b;
  localparam logic [5:0] MODE_ADDR = 6'h3c;
  localparam logic [5:0] REF_ADDR = 6'h3d;
  localparam logic [5:0] RESULT_ADDR = 6'h3e;

  // ****************************************************************
  // Field positions.
  // ****************************************************************
  localparam int CTRL_EN_BIT = 7;
  localparam int CTRL_PROC_BIT = 6;
  localparam int CTRL_CHAN_HI = 5;
  localparam int CTRL_CHAN_LO = 2;
  localparam int MODE_DIV_HI = 3;
  localparam int MODE_DIV_LO = 1;
  localparam int REF_EXT_BIT = 7;

  // ****************************************************************
  // Values after reset.
  // ****************************************************************
  localparam logic RESET_EN = 1'b0;
  localparam logic [3:0] RESET_CHAN = 4'h1;
  localparam logic [2:0] RESET_DIV = 3'h0;
  localparam logic RESET_REF_EXT = 1'b0;
  localparam logic [7:0] RESET_RESULT = 8'h00;

  // ****************************************************************
  // Channel codes and the divider mask for the largest ratio.
  // ****************************************************************
  localparam logic [3:0] CHAN_PA3 = 4'h8;
  localparam logic [3:0] CHAN_PA4 = 4'h9;
  localparam logic [3:0] CHAN_PA0 = 4'ha;
  localparam logic [3:0] CHAN_BANDGAP = 4'hf;
  localparam logic [6:0] DIV_ALL = 7'h7f;
  localparam logic [2:0] DIV_MAX_CODE = 3'h7;

  // One select line for each analog input of the converter mux.
  typedef struct packed {
    logic bandgap;
    logic port_a_line0;
    logic port_a_line4;
    logic port_a_line3;
    logic [6:0] port_b_line;
  } chan_route_t;

  // Register read and write strobes with their address and write data.
  typedef struct packed {
    logic wr;
    logic rd;
    logic [5:0] addr;
    logic [7:0] wdata;
  } io_req_t;

endpackage

// file: dv/adc_core_model.sv
`timescale 1ns/1ps
// ****
// Behavioural converter core facing the register block.
// ****
module adc_core_model
#(
  parameter int TICKS = 16
)
(
  input wire logic i_mclk,
  input wire logic i_enable,
  input wire logic i_start,
  input wire logic i_tick,
  output logic o_done = 1'b0,
  output logic [7:0] o_result = 8'h00
);
  int left = 0;
  logic [7:0] n = 8'h00;
  // Counts converter ticks after a start; the result bus toggles while it is not valid.
  always @(posedge i_mclk)
  begin
    o_done <= 1'b0;
    o_result <= ~o_result;
    if (!i_enable)
      left <= 0;
    else if (i_start)
      left <= TICKS;
    else if (left > 0 && i_tick)
    begin
      left <= left - 1;
      if (left == 1)
      begin
        o_done <= 1'b1;
        o_result <= n ^ 8'ha5;
        n <= n + 8'h01;
      end
    end
  end
endmodule // adc_core_model

// file: dv/adc_control_registers_tb.sv
`timescale 1ns/1ps
// ****
// Self-checking bench for the converter register block.
// ****
module adc_control_registers_tb;
  logic i_mclk = 1'b0;
  logic i_srst = 1'b1;
  adc_pkg::io_req_t io_q = '0;
  logic done;
  logic [7:0] res;
  logic [7:0] rdata;
  logic en;
  logic start;
  logic tick;
  logic ref_ext;
  adc_pkg::chan_route_t route;
  int bad_count = 0;
  int cmp_count = 0;
  int ticks = 0;
  int starts = 0;
  int t0;
  logic [5:0] adr [5] = '{6'h3b, 6'h3c, 6'h3d, 6'h3e, 6'h20};
  // Expected route for each channel code.
  logic [10:0] rows [16] = '{11'h000, 11'h001, 11'h002, 11'h004, 11'h008, 11'h010, 11'h020, 11'h040, 11'h080,
    11'h100, 11'h200, 11'h000, 11'h000, 11'h000, 11'h000, 11'h400};
  adc_control_registers dut (.i_mclk(i_mclk), .i_srst(i_srst), .i_io(io_q), .i_conv_done(done),
    .i_conv_result(res), .o_io_rdata(rdata), .o_conv_enable(en), .o_conv_start(start),
    .o_conv_clk_tick(tick), .o_ref_external(ref_ext), .o_chan_route(route));
  adc_core_model #(.TICKS(16)) core (.i_mclk(i_mclk), .i_enable(en), .i_start(start), .i_tick(tick),
    .o_done(done), .o_result(res));
  // Free-running system clock.
  initial forever #10 i_mclk = ~i_mclk;
  // Tallies of converter ticks and start pulses.
  always @(posedge i_mclk)
  begin
    ticks <= ticks + int'(tick);
    starts <= starts + int'(start);
  end
  task automatic chk(input string nm, input logic [10:0] exp, input logic [10:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // One register access; read data stands when the task returns.
  task automatic io(input logic w, input logic [5:0] a, input logic [7:0] d);
    @(posedge i_mclk);
    io_q <= '{wr: w, rd: !w, addr: a, wdata: d};
    @(posedge i_mclk);
    io_q <= '0;
    #1;
  endtask
  task automatic final_report();
    if (bad_count == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // Reset, table of channel codes, then the divider, reference and conversion cases.
  initial
  begin
    repeat (16) @(posedge i_mclk);
    i_srst <= 1'b0;
    foreach (adr[i])
    begin
      io(1'b0, adr[i], 8'h00);
      chk("reset read", 11'(i == 0 ? 8'h44 : 8'h00), 11'(rdata));
    end
    chk("reset route", 11'h001, route);
    for (int c = 0; c < 16; c++)
    begin
      io(1'b1, adc_pkg::CTRL_ADDR, {2'b00, 4'(c), 2'b00});
      chk("route", rows[c], route);
      io(1'b0, adc_pkg::CTRL_ADDR, 8'h00);
      chk("ctrl", 11'({2'b01, 4'(c), 2'b00}), 11'(rdata));
    end
    for (int d = 0; d < 8; d++)
    begin
      io(1'b1, adc_pkg::MODE_ADDR, {4'h0, 3'(d), 1'b0});
      io(1'b1, adc_pkg::CTRL_ADDR, 8'h84);
      repeat (4) @(posedge i_mclk);
      t0 = ticks;
      repeat (256) @(posedge i_mclk);
      chk("ticks", 11'(ticks - t0), 11'(256 >> d));
      io(1'b0, adc_pkg::MODE_ADDR, 8'h00);
      chk("mode", 11'({3'(d), 1'b0}), 11'(rdata));
      io(1'b1, adc_pkg::CTRL_ADDR, 8'h04);
      // A tick launched before the disable lands may still be counted, so the idle window starts later.
      repeat (2) @(posedge i_mclk);
      t0 = ticks;
      repeat (20) @(posedge i_mclk);
      chk("idle ticks", 11'(ticks - t0), 11'h000);
      chk("enable", 11'(en), 11'h000);
    end
    io(1'b1, adc_pkg::REF_ADDR, 8'h80);
    chk("ref", 11'(ref_ext), 11'h001);
    io(1'b0, adc_pkg::REF_ADDR, 8'h00);
    chk("ref read", 11'(rdata), 11'h000);
    io(1'b1, adc_pkg::REF_ADDR, 8'h00);
    chk("ref", 11'(ref_ext), 11'h000);
    for (int k = 0; k < 2; k++)
    begin
      io(1'b1, adc_pkg::MODE_ADDR, {4'h0, 3'(k * 2), 1'b0});
      t0 = starts;
      io(1'b1, adc_pkg::CTRL_ADDR, 8'hc4);
      io(1'b0, adc_pkg::CTRL_ADDR, 8'h00);
      chk("busy ctrl", 11'(rdata), 11'h084);
      chk("starts", 11'(starts - t0), 11'h001);
      for (int n = 0; n < 100 && rdata[6] !== 1'b1; n++)
        io(1'b0, adc_pkg::CTRL_ADDR, 8'h00);
      if (rdata[6] !== 1'b1)
      begin
        bad_count++;
        final_report();
      end
      io(1'b1, adc_pkg::RESULT_ADDR, 8'h55);
      io(1'b0, adc_pkg::RESULT_ADDR, 8'h00);
      chk("result", 11'(rdata), 11'(8'ha5 ^ 8'(k)));
    end
    io(1'b1, adc_pkg::CTRL_ADDR, 8'hc4);
    io(1'b1, adc_pkg::CTRL_ADDR, 8'h44);
    t0 = starts;
    io(1'b0, adc_pkg::CTRL_ADDR, 8'h00);
    chk("abort ctrl", 11'(rdata), 11'h044);
    chk("no start", 11'(starts - t0), 11'h000);
    // A reset in mid-run returns every register to its reset value.
    io(1'b1, adc_pkg::MODE_ADDR, 8'h0a);
    io(1'b1, adc_pkg::REF_ADDR, 8'h80);
    io(1'b1, adc_pkg::CTRL_ADDR, 8'hbc);
    @(posedge i_mclk);
    i_srst <= 1'b1;
    repeat (2) @(posedge i_mclk);
    i_srst <= 1'b0;
    foreach (adr[i])
    begin
      io(1'b0, adr[i], 8'h00);
      chk("srst read", 11'(i == 0 ? 8'h44 : 8'h00), 11'(rdata));
    end
    chk("srst route", 11'h001, route);
    chk("srst ref", 11'(ref_ext), 11'h000);
    chk("srst enable", 11'(en), 11'h000);
    final_report();
  end
endmodule // adc_control_registers_tb
